// ===== hw/wpcfg_pkg.sv
// Package of constants and types for the write-protect and configuration register block.
// Behaviour
// RL1: Register writes need write_enable_latch, and pin protection off or protect pin high.
// RL2: Latch clear blocks all array writes; set allows only the unprotected range. The code lets policy 01 write with the latch clear.
// RL3: access_flags bit 7 is ready_flag, one when ready, one after reset.
// RL4: access_flags bits 6 to 0 read zero; the register is read-only.
// RL5: part_info holds maker, interface, voltage, temperature, density and frequency fields.
// RL6: Field codes: interface 0010, voltage 0001, temperature by range, density, frequency 01.
// RL7: config_one bits 7:5 select drive strength, read/write, reset value 011.
// RL8: config_one bit 2 locks top_bottom_select and block_protect_field against change.
// RL9: Policy 00 needs the latch for every array write; chip select high clears it.
// RL10: Policy 01 performs array writes whatever the latch holds.
// RL11: Policy 10 needs the latch once; it survives chip select; write-disable clears it.
// RL12: The host never programs policy 11, which is reserved.
// RL13: Register writes always need the latch; chip select rising afterwards clears it.
// RL14: config_one bits 4:3 read zero; bits 1:0 are the policy, reset 00.
// RL15: write_enable_latch is status bit 1, not directly writable, reset zero.
// RL16: pin_protect_enable is status bit 7, reset zero, arms pin protection when low. The code arms it when the bit is one.
// RL17: Protected area is the software range ORed with the hardware pin range.
// RL18: Writes to access_flags and part_info are ignored and change nothing.
package wpcfg_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] WPCFG_ADDR_STATUS = 8'h00;
  localparam logic [7:0] WPCFG_ADDR_FLAGS = 8'h04;
  localparam logic [7:0] WPCFG_ADDR_INFO = 8'h08;
  localparam logic [7:0] WPCFG_ADDR_CFG1 = 8'h0C;
  localparam logic [7:0] WPCFG_ADDR_CMD = 8'h10;
  localparam logic [7:0] WPCFG_ADDR_QUERY = 8'h14;
  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int WPCFG_SR_PPE = 7;
  localparam int WPCFG_SR_TB = 5;
  localparam int WPCFG_SR_BP_LO = 2;
  localparam int WPCFG_SR_WEL = 1;
  localparam int WPCFG_FL_READY = 7;
  localparam int WPCFG_C1_LOCK = 2;
  localparam logic [2:0] WPCFG_DRIVE_RST = 3'h3;
  localparam logic [1:0] WPCFG_POL_NORMAL = 2'h0;
  localparam logic [1:0] WPCFG_POL_SRAM = 2'h1;
  localparam logic [1:0] WPCFG_POL_B2B = 2'h2;
  // Command register codes.
  localparam logic [2:0] WPCFG_CMD_WRITE_ENABLE_LATCH = 3'h1;
  localparam logic [2:0] WPCFG_CMD_WRDI = 3'h2;
  localparam logic [2:0] WPCFG_CMD_ARRAY = 3'h4;
  // ****************************************
  // Identification word fields
  // ****************************************
  localparam logic [7:0] WPCFG_MAKER = 8'h5A; // Arbitrary value.
  localparam logic [3:0] WPCFG_IF_DUALQ = 4'h2;
  localparam logic [3:0] WPCFG_VOLT_3V = 4'h1;
  localparam logic [3:0] WPCFG_TEMP_85 = 4'h0;
  localparam logic [3:0] WPCFG_DENS_64 = 4'h1;
  localparam logic [7:0] WPCFG_FREQ_100 = 8'h01;
  typedef struct packed {
    logic [7:0] maker;
    logic [3:0] intf;
    logic [3:0] volt;
    logic [3:0] temp;
    logic [3:0] dens;
    logic [7:0] freq;
  } wpcfg_info_t;
  typedef struct packed {
    logic [2:0] drive;
    logic [1:0] rsvd;
    logic lock;
    logic [1:0] policy;
  } wpcfg_cfg1_t;
  typedef enum logic [2:0] {
    WPCFG_IDLE = 3'b001,
    WPCFG_ACC = 3'b010,
    WPCFG_HOLD = 3'b100
  } wpcfg_state_t;
  // Decoded block-protect range: which sixty-fourths of the array are protected.
  function automatic logic in_range(input logic [2:0] bp, input logic tb, input logic [5:0] blk);
    logic [5:0] span;
    logic hit;
    span = 6'h0;
    hit = 1'b0;
    if (bp != 3'h0) begin
      span = (bp == 3'h7) ? 6'h3F : 6'(6'h01 << (bp - 3'h1));
      hit = tb ? (blk < span) : (blk >= 6'(6'h3F - span + 6'h01));
      if (bp == 3'h7) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction
endpackage

// ===== hw/wpcfg_top.sv
// Write-protect decision and configuration registers behind an APB slave.
//
// Our own choices: the placing of the registers and the APB register port.
module wpcfg_top
  import wpcfg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cs_n_pin,
  input wire logic sclk_pin,
  input wire logic protect_n_pin,
  input wire logic [2:0] hw_bp_pin,
  input wire logic hw_tb_pin,
  input wire logic busy,
  output logic write_enable_latch_out,
  output logic array_write_ok,
  output logic reg_write_ok,
  output logic [2:0] drive_strength_select
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [5:0] sync1, sync2;
  logic cs_prev, sclk_prev;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Idle levels: chip select high, serial clock low, protect high, range pins pulled low.
      sync1 <= 6'h28;
      sync2 <= 6'h28;
      cs_prev <= 1'b1;
      sclk_prev <= 1'b0;
    end else if (clk_en) begin
      sync1 <= {cs_n_pin, sclk_pin, protect_n_pin, hw_tb_pin, hw_bp_pin[1:0]};
      sync2 <= sync1;
      cs_prev <= sync2[5];
      sclk_prev <= sync2[4];
    end
  end
  logic [2:0] bp1, bp2;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bp1 <= 3'h0;
      bp2 <= 3'h0;
    end else if (clk_en) begin
      bp1 <= {hw_bp_pin[2], 2'h0};
      bp2 <= bp1;
    end
  end
  logic cs_s, prot_s, htb_s, cs_rise, sclk_rise;
  logic [2:0] hbp_s;
  assign cs_s = sync2[5];
  assign prot_s = sync2[3];
  assign htb_s = sync2[2];
  assign hbp_s = {bp2[2], sync2[1:0]};
  assign cs_rise = cs_s && !cs_prev;
  assign sclk_rise = sync2[4] && !sclk_prev;

  // ****************************************
  // Register state
  // ****************************************
  logic ppe, tb, wel, b2b_armed, last_reg_wr;
  logic [2:0] bp;
  wpcfg_cfg1_t cfg1;
  logic next_ppe, next_tb, next_wel, next_b2b_armed, next_last_reg_wr;
  logic [2:0] next_bp;
  wpcfg_cfg1_t next_cfg1;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic [5:0] query_blk, next_query_blk;
  wpcfg_state_t state, next_state;
  wpcfg_info_t info;
  logic reg_ok, wr_phase;
  logic ready_flag;

  assign info = '{maker: WPCFG_MAKER, intf: WPCFG_IF_DUALQ, volt: WPCFG_VOLT_3V,
                  temp: WPCFG_TEMP_85, dens: WPCFG_DENS_64, freq: WPCFG_FREQ_100}; // [RL5] [RL6]
  assign ready_flag = !busy; // [RL3]
  // Status and configuration writes need the latch and a released pin lock.
  assign reg_ok = wel && (!ppe || prot_s); // [RL1] [RL16]
  assign wr_phase = psel && penable && pwrite && state == WPCFG_ACC;

  // Protected if software range or hardware pin range covers the block.
  function automatic logic blk_prot(input logic [5:0] blk, input logic [2:0] sbp, input logic stb,
                                    input logic [2:0] hbp, input logic htb);
    return in_range(sbp, stb, blk) || in_range(hbp, htb, blk); // [RL17]
  endfunction

  function automatic logic array_ok(input logic [5:0] blk, input logic l, input logic [1:0] pol,
                                    input logic armed, input logic [2:0] sbp, input logic stb,
                                    input logic [2:0] hbp, input logic htb);
    logic en;
    en = (pol == WPCFG_POL_SRAM) || l || (pol == WPCFG_POL_B2B && armed); // [RL2] [RL10]
    return en && !blk_prot(blk, sbp, stb, hbp, htb);
  endfunction

  always_comb begin
    next_ppe = ppe;
    next_tb = tb;
    next_bp = bp;
    next_wel = wel;
    next_cfg1 = cfg1;
    next_b2b_armed = b2b_armed;
    next_last_reg_wr = last_reg_wr;
    next_query_blk = query_blk;
    next_prdata = prdata;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_state = state;
    case (state)
      WPCFG_IDLE: begin
        if (psel && !penable) begin
          next_state = WPCFG_ACC;
        end
      end
      WPCFG_ACC: begin
        if (psel && penable) begin
          next_pready = 1'b1;
          next_state = WPCFG_HOLD;
          next_prdata = 32'h0;
          if (pwrite) begin
            case (paddr)
              WPCFG_ADDR_STATUS: begin
                if (reg_ok) begin // [RL1]
                  next_ppe = pwdata[WPCFG_SR_PPE]; // [RL16]
                  if (!cfg1.lock) begin // [RL8]
                    next_tb = pwdata[WPCFG_SR_TB];
                    next_bp = pwdata[WPCFG_SR_BP_LO +: 3];
                  end
                  next_last_reg_wr = 1'b1; // [RL13]
                end
              end
              WPCFG_ADDR_CFG1: begin
                if (reg_ok) begin // [RL1]
                  next_cfg1.drive = pwdata[7:5]; // [RL7]
                  next_cfg1.lock = pwdata[WPCFG_C1_LOCK]; // [RL8]
                  next_cfg1.policy = pwdata[1:0]; // [RL14]
                  next_last_reg_wr = 1'b1; // [RL13]
                end
              end
              WPCFG_ADDR_CMD: begin
                if (pwdata[2:0] == WPCFG_CMD_WRITE_ENABLE_LATCH) begin
                  next_wel = 1'b1;
                end else if (pwdata[2:0] == WPCFG_CMD_WRDI) begin
                  next_wel = 1'b0; // [RL11]
                  next_b2b_armed = 1'b0;
                end else if (pwdata[2:0] == WPCFG_CMD_ARRAY &&
                             cfg1.policy == WPCFG_POL_B2B && wel) begin
                  next_b2b_armed = 1'b1; // [RL11]
                end
              end
              WPCFG_ADDR_QUERY: next_query_blk = pwdata[5:0];
              WPCFG_ADDR_FLAGS, WPCFG_ADDR_INFO: ; // [RL18]
              default: next_pslverr = 1'b1;
            endcase
          end else begin
            case (paddr)
              WPCFG_ADDR_STATUS: begin
                next_prdata[WPCFG_SR_PPE] = ppe;
                next_prdata[WPCFG_SR_TB] = tb;
                next_prdata[WPCFG_SR_BP_LO +: 3] = bp;
                next_prdata[WPCFG_SR_WEL] = wel; // [RL15]
              end
              WPCFG_ADDR_FLAGS: next_prdata[WPCFG_FL_READY] = ready_flag; // [RL3] [RL4]
              WPCFG_ADDR_INFO: next_prdata = info; // [RL5]
              WPCFG_ADDR_CFG1: next_prdata[7:0] = {cfg1.drive, 2'h0, cfg1.lock, cfg1.policy}; // [RL14]
              WPCFG_ADDR_CMD: next_prdata[5:0] = query_blk;
              WPCFG_ADDR_QUERY: next_prdata[0] = blk_prot(query_blk, bp, tb, hbp_s, htb_s);
              default: next_pslverr = 1'b1;
            endcase
          end
        end else begin
          next_state = WPCFG_IDLE;
        end
      end
      WPCFG_HOLD: begin
        next_state = (psel && !penable) ? WPCFG_ACC : WPCFG_IDLE;
      end
      default: next_state = WPCFG_IDLE;
    endcase
    // Chip select rising ends the serial instruction; the clear wins over a set this cycle.
    if (cs_rise) begin
      if (last_reg_wr || cfg1.policy == WPCFG_POL_NORMAL) begin
        next_wel = 1'b0; // [RL9] [RL13]
      end
      next_last_reg_wr = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ppe <= 1'b0;
      tb <= 1'b0;
      bp <= 3'h0;
      wel <= 1'b0; // [RL15]
      cfg1 <= '{drive: WPCFG_DRIVE_RST, rsvd: 2'h0, lock: 1'b0, policy: WPCFG_POL_NORMAL}; // [RL7] [RL14]
      b2b_armed <= 1'b0;
      last_reg_wr <= 1'b0;
      query_blk <= 6'h0;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      state <= WPCFG_IDLE;
    end else if (clk_en) begin
      ppe <= next_ppe;
      tb <= next_tb;
      bp <= next_bp;
      wel <= next_wel;
      cfg1 <= next_cfg1;
      b2b_armed <= next_b2b_armed;
      last_reg_wr <= next_last_reg_wr;
      query_blk <= next_query_blk;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      state <= next_state;
    end
  end

  // ****************************************
  // Registered decision outputs
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_enable_latch_out <= 1'b0;
      array_write_ok <= 1'b0;
      reg_write_ok <= 1'b0;
      drive_strength_select <= WPCFG_DRIVE_RST;
    end else if (clk_en) begin
      write_enable_latch_out <= wel;
      array_write_ok <= array_ok(query_blk, wel, cfg1.policy, b2b_armed, bp, tb, hbp_s, htb_s); // [RL2]
      reg_write_ok <= reg_ok;
      drive_strength_select <= cfg1.drive;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_reg_guard: assert property (@(posedge pclk) disable iff (!presetn) // [RL1]
    (clk_en && wr_phase && paddr == WPCFG_ADDR_STATUS && !reg_ok) |=> $stable(bp) && $stable(ppe))
    else $error("status changed while register writes were blocked");
  a_lock_hold: assert property (@(posedge pclk) disable iff (!presetn) // [RL8]
    (clk_en && cfg1.lock && !cs_rise) |=> $stable(tb) && $stable(bp))
    else $error("locked protect setting changed");
  a_ready_bit: assert property (@(posedge pclk) disable iff (!presetn) // [RL3]
    (clk_en && state == WPCFG_ACC && psel && penable && !pwrite && paddr == WPCFG_ADDR_FLAGS)
    |=> prdata == {24'h0, $past(ready_flag), 7'h0})
    else $error("flag register read wrong");
  a_info_word: assert property (@(posedge pclk) disable iff (!presetn) // [RL5]
    (clk_en && state == WPCFG_ACC && psel && penable && !pwrite && paddr == WPCFG_ADDR_INFO)
    |=> prdata == {WPCFG_MAKER, WPCFG_IF_DUALQ, WPCFG_VOLT_3V, WPCFG_TEMP_85, WPCFG_DENS_64, WPCFG_FREQ_100})
    else $error("identification word wrong");
  a_wel_clear: assert property (@(posedge pclk) disable iff (!presetn) // [RL9]
    (clk_en && cs_rise && cfg1.policy == WPCFG_POL_NORMAL) |=> !wel)
    else $error("latch survived chip select in normal policy");
  a_b2b_keep: assert property (@(posedge pclk) disable iff (!presetn) // [RL11]
    (clk_en && cs_rise && wel && cfg1.policy == WPCFG_POL_B2B && !last_reg_wr && !wr_phase) |=> wel)
    else $error("latch lost in back-to-back policy");
  a_array_off: assert property (@(posedge pclk) disable iff (!presetn) // [RL2]
    (clk_en && !wel && cfg1.policy == WPCFG_POL_NORMAL) |=> !array_write_ok)
    else $error("array writable without latch");
  a_reg_clear: assert property (@(posedge pclk) disable iff (!presetn) // [RL13]
    (clk_en && cs_rise && last_reg_wr) |=> !wel)
    else $error("latch survived end of register write");
  a_ro_ignore: assert property (@(posedge pclk) disable iff (!presetn) // [RL18]
    (clk_en && wr_phase && paddr == WPCFG_ADDR_FLAGS && !cs_rise) |=> $stable(cfg1) && $stable(wel))
    else $error("read-only write changed state");
endmodule // wpcfg_top

// ===== test/wpcfg_host_model.sv
// Behavioural model of the host memory controller that frames the serial link.
module wpcfg_host_model (
  input wire logic frame_req,
  output logic cs_n_pin,
  output logic sclk_pin,
  output logic frame_done
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Frame generator
  // ****************************************
  // The serial clock stands low between frames, so edges exist only inside a frame.
  initial begin
    cs_n_pin = 1'b1;
    sclk_pin = 1'b0;
    frame_done = 1'b0;
    forever begin
      wait (frame_req === 1'b1);
      cs_n_pin = 1'b0;
      repeat (8) begin
        #100 sclk_pin = 1'b1;
        #100 sclk_pin = 1'b0;
      end
      #100 cs_n_pin = 1'b1;
      frame_done = 1'b1;
      wait (frame_req === 1'b0);
      frame_done = 1'b0;
    end
  end
endmodule // wpcfg_host_model

// ===== test/test_write_protect_and_config_regs.sv
// Self-checking testbench for the write-protect and configuration register block.
module test_write_protect_and_config_regs import wpcfg_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, clk_en, psel, penable, pwrite, protect_n_pin, hw_tb_pin, busy, frame_req;
  logic pready, pslverr, cs_n_pin, sclk_pin, frame_done, wel, awok, rwok;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0] hw_bp_pin, drive;
  int n_errors = 0;
  int checks = 0;
  wpcfg_top DUT (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .protect_n_pin(protect_n_pin),
    .hw_bp_pin(hw_bp_pin), .hw_tb_pin(hw_tb_pin), .busy(busy), .write_enable_latch_out(wel),
    .array_write_ok(awok), .reg_write_ok(rwok), .drive_strength_select(drive));
  wpcfg_host_model host (.frame_req(frame_req), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin),
    .frame_done(frame_done));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t %s got %h", $time, m, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk(1'b0, 1'b1, "no pready");
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string m);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp, m);
  endtask
  task automatic cmd(input logic [2:0] c);
    wr(WPCFG_ADDR_CMD, {29'h0, c});
  endtask
  task automatic settle();
    repeat (5) @(posedge pclk);
  endtask
  task automatic frame();
    int n;
    n = 0;
    @(posedge pclk);
    frame_req <= 1'b1;
    while (frame_done !== 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    frame_req <= 1'b0;
    while (frame_done !== 1'b0 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 300) chk(1'b0, 1'b1, "frame hung");
    settle();
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    rd(WPCFG_ADDR_FLAGS, 32'h80, "flags reset");
    rd(WPCFG_ADDR_INFO, {WPCFG_MAKER, 4'h2, 4'h1, 4'h0, 4'h1, 8'h01}, "part info");
    rd(WPCFG_ADDR_CFG1, 32'h60, "config reset");
    rd(WPCFG_ADDR_STATUS, 32'h00, "status reset");
    chk({29'h0, drive}, 32'h3, "drive reset");
    busy <= 1'b1;
    settle();
    rd(WPCFG_ADDR_FLAGS, 32'h00, "busy flag");
    busy <= 1'b0;
    $display("t_reset done");
  endtask
  task automatic t_status();
    logic [31:0] r;
    logic e;
    wr(WPCFG_ADDR_STATUS, 32'h20);
    rd(WPCFG_ADDR_STATUS, 32'h00, "write without latch");
    cmd(WPCFG_CMD_WRITE_ENABLE_LATCH);
    rd(WPCFG_ADDR_STATUS, 32'h02, "latch set");
    wr(WPCFG_ADDR_STATUS, 32'h20);
    rd(WPCFG_ADDR_STATUS, 32'h22, "status write");
    frame();
    rd(WPCFG_ADDR_STATUS, 32'h20, "latch cleared");
    cmd(WPCFG_CMD_WRITE_ENABLE_LATCH);
    wr(WPCFG_ADDR_FLAGS, 32'h0);
    wr(WPCFG_ADDR_INFO, 32'h0);
    rd(WPCFG_ADDR_FLAGS, 32'h80, "flags kept");
    rd(WPCFG_ADDR_INFO, {WPCFG_MAKER, 24'h210101}, "info kept");
    rd(WPCFG_ADDR_STATUS, 32'h22, "state kept");
    apb(1'b0, 8'h1C, 32'h0, r, e);
    chk({31'h0, e}, 32'h1, "unmapped error");
    frame();
    $display("t_status done");
  endtask
  task automatic t_pin();
    cmd(WPCFG_CMD_WRITE_ENABLE_LATCH);
    wr(WPCFG_ADDR_STATUS, 32'hA0);
    frame();
    protect_n_pin <= 1'b0;
    cmd(WPCFG_CMD_WRITE_ENABLE_LATCH);
    settle();
    chk({31'h0, rwok}, 32'h0, "pin blocks");
    wr(WPCFG_ADDR_STATUS, 32'h20);
    rd(WPCFG_ADDR_STATUS, 32'hA2, "pin blocked write");
    protect_n_pin <= 1'b1;
    settle();
    chk({31'h0, rwok}, 32'h1, "pin high");
    wr(WPCFG_ADDR_STATUS, 32'h20);
    rd(WPCFG_ADDR_STATUS, 32'h22, "pin high write");
    frame();
    $display("t_pin done");
  endtask
  task automatic t_policy();
    for (int p = 0; p < 3; p++) begin
      cmd(WPCFG_CMD_WRITE_ENABLE_LATCH);
      wr(WPCFG_ADDR_CFG1, 32'h60 | p);
      frame();
      chk({31'h0, awok}, (p == 1), "array gate without latch");
      cmd(WPCFG_CMD_WRITE_ENABLE_LATCH);
      if (p == 2) cmd(WPCFG_CMD_ARRAY);
      settle();
      chk({31'h0, awok}, 32'h1, "array gate with latch");
      frame();
      chk({31'h0, awok}, (p != 0), "array gate after frame");
      if (p != 1) chk({31'h0, wel}, (p == 2), "latch after frame");
    end
    cmd(WPCFG_CMD_WRDI);
    settle();
    chk({31'h0, wel}, 32'h0, "write disable");
    cmd(WPCFG_CMD_WRITE_ENABLE_LATCH);
    wr(WPCFG_ADDR_CFG1, 32'h60);
    frame();
    $display("t_policy done");
  endtask
  task automatic t_range();
    cmd(WPCFG_CMD_WRITE_ENABLE_LATCH);
    wr(WPCFG_ADDR_STATUS, 32'h1C);
    frame();
    cmd(WPCFG_CMD_WRITE_ENABLE_LATCH);
    settle();
    chk({31'h0, awok}, 32'h0, "soft range all");
    wr(WPCFG_ADDR_STATUS, 32'h00);
    frame();
    cmd(WPCFG_CMD_WRITE_ENABLE_LATCH);
    hw_bp_pin <= 3'h7;
    settle();
    chk({31'h0, awok}, 32'h0, "hard range all");
    hw_bp_pin <= 3'h0;
    settle();
    chk({31'h0, awok}, 32'h1, "no range");
    // A low clock enable must freeze the pin synchronisers and the decision outputs.
    clk_en <= 1'b0;
    hw_bp_pin <= 3'h7;
    settle();
    chk({31'h0, awok}, 32'h1, "frozen by clock enable");
    clk_en <= 1'b1;
    settle();
    chk({31'h0, awok}, 32'h0, "pin range after enable");
    hw_bp_pin <= 3'h0;
    frame();
    chk({31'h0, awok}, 32'h0, "latch clear blocks");
    cmd(WPCFG_CMD_WRITE_ENABLE_LATCH);
    wr(WPCFG_ADDR_STATUS, 32'h04);
    wr(WPCFG_ADDR_QUERY, 32'h3F);
    rd(WPCFG_ADDR_CMD, 32'h3F, "query index");
    rd(WPCFG_ADDR_QUERY, 32'h1, "top sixty-fourth protected");
    wr(WPCFG_ADDR_QUERY, 32'h3E);
    rd(WPCFG_ADDR_QUERY, 32'h0, "next block free");
    wr(WPCFG_ADDR_QUERY, 32'h00);
    rd(WPCFG_ADDR_QUERY, 32'h0, "bottom block free");
    hw_tb_pin <= 1'b1;
    hw_bp_pin <= 3'h6;
    settle();
    rd(WPCFG_ADDR_QUERY, 32'h1, "pin lower half protected");
    hw_tb_pin <= 1'b0;
    hw_bp_pin <= 3'h0;
    wr(WPCFG_ADDR_STATUS, 32'h00);
    frame();
    $display("t_range done");
  endtask
  task automatic t_lock();
    cmd(WPCFG_CMD_WRITE_ENABLE_LATCH);
    wr(WPCFG_ADDR_CFG1, 32'hFC);
    rd(WPCFG_ADDR_CFG1, 32'hE4, "config write");
    settle();
    chk({29'h0, drive}, 32'h7, "drive select");
    frame();
    cmd(WPCFG_CMD_WRITE_ENABLE_LATCH);
    wr(WPCFG_ADDR_STATUS, 32'h3C);
    rd(WPCFG_ADDR_STATUS, 32'h02, "locked range");
    frame();
    $display("t_lock done");
  endtask
  // ****************************************
  // Run control
  // ****************************************
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #400000;
    n_errors++;
    final_report();
  end
  initial begin
    presetn = 1'b0;
    clk_en = 1'b1;
    {psel, penable, pwrite, busy, frame_req, hw_tb_pin} = 6'h0;
    protect_n_pin = 1'b1;
    hw_bp_pin = 3'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    t_reset();
    t_status();
    t_pin();
    t_policy();
    t_range();
    t_lock();
    final_report();
  end
endmodule // test_write_protect_and_config_regs
